// *** verilog/gwelp_port.sv ***
// Purpose: gpio port with per-pin config, wake and interrupt events, either-edge and led blink
// Assumes: runtime register strobes are synchronous to mclk; pins are asynchronous
// Notes: pin outputs, enables and event outputs are registered
// Behaviour
// - config bit 0 direction, bit 1 polarity, bit 7 driver type
// - direction 0 output, 1 input; polarity 1 inverts
// - driver type applies to port use and the group interrupt pin function
// - polarity applies to port and alternates, except drive density, joystick, either-edge
// - joystick alternate on ports 14 to 17 is open-drain, non-inverted
// - input pin reads latched level xor polarity; writes ignored
// - output pin drives stored bit xor polarity; read returns stored bit
// - output pins never set wake or interrupt status
// - polarity picks edge setting wake status; default rising
// - wake event needs status, pin enable and global enable
// - wake status clears only on write of one
// - wake status bits placed in register pairs two to five
// - interrupt status bits placed in register pairs three to five
// - six either-edge pins set wake and interrupt status on both edges
// - either-edge mode ignores direction, polarity, type; read still inverted
// - either-edge pin events need mode and enable; status clears on one
// - summary register holds a status bit per either-edge pin
// - status bits record events regardless of enables or mode
// - ports 60 and 61 led off, on or blink via two registers
// - blink timed by standby clock edges; no clock, no blink
// - ports 32, 33, 53 reset to output low; revert without main power
// - port 43 resets to plain port function
// - interrupt request is or of status and enable products
`timescale 1ns/100ps
`default_nettype none
module gwelp_port
	import gwelp_pkg::*;
#(
	parameter int BLINK_EDGES = BLINK_HALF_EDGES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// runtime registers
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// pins
	input wire logic [NUM_SLOTS-1:0] pin_in,
	output logic [NUM_SLOTS-1:0] pin_out,
	output logic [NUM_SLOTS-1:0] pin_oe,
	input wire logic [NUM_SLOTS-1:0] alt_out,
	// standby
	input wire logic standby_clk_pin,
	input wire logic main_power_off_pin,
	// events
	output logic wake_event_out,
	output logic intr_req_out
);
	localparam int BW = $clog2(BLINK_EDGES + 1);
	localparam int WAKE_BITS = NUM_WAKE_REGS * 8;
	localparam int INTR_BITS = NUM_INTR_REGS * 8;

	if (BLINK_EDGES < 2) begin : g_check
		$error("gwelp_port blink count must be at least two");
	end

	logic [7:0] cfg_reg [NUM_SLOTS];
	logic [NUM_SLOTS-1:0] data_reg;
	logic [WAKE_BITS-1:0] wake_sts_reg;
	logic [WAKE_BITS-1:0] wake_en_reg;
	logic [INTR_BITS-1:0] intr_sts_reg;
	logic [INTR_BITS-1:0] intr_en_reg;
	logic global_wake_en_reg;
	logic [NUM_EE-1:0] ee_status_reg;
	logic [NUM_EE-1:0] ee_select_reg;
	logic [7:0] led_ctl_reg [2];
	logic [BW-1:0] blink_cnt_reg;
	logic blink_phase_reg;
	logic [1:0] led_level;
	logic [7:0] rdata_next;
	logic [WAKE_BITS-1:0] wake_clr;
	logic [INTR_BITS-1:0] intr_clr;
	logic [NUM_EE-1:0] ee_clr;
	logic [NUM_SLOTS-1:0] ee_slot;
	logic [NUM_EE-1:0] ee_any_edge;
	logic [NUM_SLOTS+SYNC_EXTRA-1:0] sync_level;
	logic [NUM_SLOTS+SYNC_EXTRA-1:0] sync_rise;
	logic [NUM_SLOTS+SYNC_EXTRA-1:0] sync_fall;
	wire [NUM_SLOTS-1:0] pin_rise;
	wire [NUM_SLOTS-1:0] pin_fall;
	wire [NUM_SLOTS-1:0] out_next;
	wire [NUM_SLOTS-1:0] oe_next;
	wire [NUM_SLOTS-1:0] as_out;
	wire [NUM_SLOTS-1:0] rd_bit;
	wire [NUM_SLOTS-1:0] edge_ev;
	wire [WAKE_BITS-1:0] wake_set;
	wire [INTR_BITS-1:0] intr_set;
	wire main_power_off;
	wire standby_edge;

	gwelp_pin_sync #(
		.WIDTH(NUM_SLOTS + SYNC_EXTRA)
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin_raw({main_power_off_pin, standby_clk_pin, pin_in}),
		.level(sync_level),
		.rise(sync_rise),
		.fall(sync_fall)
	);

	assign pin_rise = sync_rise[NUM_SLOTS-1:0];
	assign pin_fall = sync_fall[NUM_SLOTS-1:0];
	assign standby_edge = sync_rise[NUM_SLOTS];
	assign main_power_off = sync_level[NUM_SLOTS+1];

	// either-edge selection spread onto slots
	always_comb begin
		ee_slot = '0;
		ee_any_edge = '0;
		for (int k = 0; k < NUM_EE; k++) begin
			ee_slot[EE_MAP[k][5:0]] = ee_select_reg[k];
			ee_any_edge[k] = pin_rise[EE_MAP[k][5:0]] | pin_fall[EE_MAP[k][5:0]];
		end
	end

	// per-pin drive, read value and event
	for (genvar gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
		wire revert = main_power_off && REVERT_MASK[gi];
		wire alt = (cfg_reg[gi][CFG_FUNC_MSB:CFG_FUNC_LSB] != FUNC_PORT) && !revert;
		wire pol = cfg_reg[gi][CFG_POL_BIT] && !revert;
		wire joy = alt && JOY_MASK[gi];
		wire no_pol = joy || (alt && gi == SLOT_DRIVE_DENSITY);
		wire led_val = (gi == SLOT_LED_ONE) ? led_level[0] : led_level[1];
		wire alt_val = (gi == SLOT_GROUP_INTR) ? ~intr_req_out : (LED_MASK[gi] ? led_val : alt_out[gi]);
		wire val = (alt ? alt_val : data_reg[gi]) ^ (pol && !no_pol);
		wire od = joy || (cfg_reg[gi][CFG_TYPE_BIT] == TYPE_OPEN_DRAIN);
		wire drive = !ee_slot[gi] && (alt || as_out[gi]);
		assign as_out[gi] = ((cfg_reg[gi][CFG_DIR_BIT] == DIR_OUTPUT) || revert) && !ee_slot[gi];
		assign oe_next[gi] = drive && (od ? !val : 1'b1);
		assign out_next[gi] = od ? 1'b0 : val;
		assign rd_bit[gi] = as_out[gi] ? data_reg[gi] : (sync_level[gi] ^ cfg_reg[gi][CFG_POL_BIT]);
		assign edge_ev[gi] = ee_slot[gi] ? (pin_rise[gi] | pin_fall[gi]) :
			(!as_out[gi] && (pol ? pin_fall[gi] : pin_rise[gi]));
	end

	for (genvar gw = 0; gw < WAKE_BITS; gw++) begin : g_wake_map
		if (WAKE_MAP[gw] == SLOT_NONE) begin : g_none
			assign wake_set[gw] = 1'b0;
		end else begin : g_pin
			assign wake_set[gw] = edge_ev[WAKE_MAP[gw][5:0]];
		end
	end

	for (genvar gn = 0; gn < INTR_BITS; gn++) begin : g_intr_map
		if (INTR_MAP[gn] == SLOT_NONE) begin : g_none
			assign intr_set[gn] = 1'b0;
		end else begin : g_pin
			assign intr_set[gn] = edge_ev[INTR_MAP[gn][5:0]];
		end
	end

	// write-one-to-clear masks
	always_comb begin
		wake_clr = '0;
		intr_clr = '0;
		ee_clr = '0;
		for (int k = 0; k < NUM_WAKE_REGS; k++) begin
			if (reg_wr && reg_addr == 8'(WAKE_STS_BASE + k)) begin
				wake_clr[k*8 +: 8] = reg_wdata;
			end
		end
		for (int k = 0; k < NUM_INTR_REGS; k++) begin
			if (reg_wr && reg_addr == 8'(INTR_STS_BASE + k)) begin
				intr_clr[k*8 +: 8] = reg_wdata;
			end
		end
		if (reg_wr && reg_addr == EE_STATUS_SUMMARY) begin
			ee_clr = reg_wdata[NUM_EE-1:0];
		end
	end

	// status registers, a new event wins over a clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_sts_reg <= '0;
			intr_sts_reg <= '0;
			ee_status_reg <= '0;
		end else begin
			wake_sts_reg <= (wake_sts_reg & ~wake_clr) | wake_set;
			intr_sts_reg <= (intr_sts_reg & ~intr_clr) | intr_set;
			ee_status_reg <= (ee_status_reg & ~ee_clr) | ee_any_edge;
		end
	end

	// configuration and enables
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < NUM_SLOTS; k++) begin
				cfg_reg[k] <= REVERT_MASK[k] ? CFG_RESET_OUT : CFG_RESET_IN;
			end
			wake_en_reg <= '0;
			intr_en_reg <= '0;
			global_wake_en_reg <= 1'b0;
			ee_select_reg <= '0;
			led_ctl_reg[0] <= ZERO_BYTE;
			led_ctl_reg[1] <= ZERO_BYTE;
		end else if (reg_wr) begin
			for (int k = 0; k < NUM_SLOTS; k++) begin
				if (reg_addr == 8'(CFG_BASE + k)) begin
					cfg_reg[k] <= reg_wdata;
				end
			end
			for (int k = 0; k < NUM_WAKE_REGS; k++) begin
				if (reg_addr == 8'(WAKE_EN_BASE + k)) begin
					wake_en_reg[k*8 +: 8] <= reg_wdata;
				end
			end
			for (int k = 0; k < NUM_INTR_REGS; k++) begin
				if (reg_addr == 8'(INTR_EN_BASE + k)) begin
					intr_en_reg[k*8 +: 8] <= reg_wdata;
				end
			end
			if (reg_addr == GLOBAL_WAKE_EN) begin
				global_wake_en_reg <= reg_wdata[0];
			end
			if (reg_addr == EE_DETECT_SELECT) begin
				ee_select_reg <= reg_wdata[NUM_EE-1:0];
			end
			if (reg_addr == LED_ONE_CONTROL) begin
				led_ctl_reg[0] <= reg_wdata;
			end
			if (reg_addr == LED_TWO_CONTROL) begin
				led_ctl_reg[1] <= reg_wdata;
			end
		end
	end

	// data register, only output pins store
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			data_reg <= '0;
		end else begin
			for (int k = 0; k < NUM_SLOTS; k++) begin
				if (reg_wr && reg_addr == 8'(DATA_BASE + k / 8) && as_out[k]) begin
					data_reg[k] <= reg_wdata[k % 8];
				end
			end
		end
	end

	// blink timebase from standby clock edges
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt_reg <= '0;
			blink_phase_reg <= 1'b0;
		end else if (standby_edge) begin
			if (blink_cnt_reg == BW'(BLINK_EDGES - 1)) begin
				blink_cnt_reg <= '0;
				blink_phase_reg <= !blink_phase_reg;
			end else begin
				blink_cnt_reg <= blink_cnt_reg + 1'b1;
			end
		end
	end

	always_comb begin
		for (int j = 0; j < 2; j++) begin
			unique case (gwelp_led_mode_type'(led_ctl_reg[j][1:0]))
				GWELP_LED_OFF: led_level[j] = 1'b0;
				GWELP_LED_BLINK: led_level[j] = blink_phase_reg;
				GWELP_LED_ON, GWELP_LED_ON_ALT: led_level[j] = 1'b1;
			endcase
		end
	end

	// read mux
	always_comb begin
		rdata_next = ZERO_BYTE;
		if (reg_addr < 8'(CFG_BASE + NUM_SLOTS)) begin
			rdata_next = cfg_reg[6'(reg_addr - CFG_BASE)];
		end
		for (int k = 0; k < NUM_GROUPS; k++) begin
			if (reg_addr == 8'(DATA_BASE + k)) begin
				rdata_next = rd_bit[k*8 +: 8] & GROUP_MASK[k];
			end
		end
		for (int k = 0; k < NUM_WAKE_REGS; k++) begin
			if (reg_addr == 8'(WAKE_STS_BASE + k)) begin
				rdata_next = wake_sts_reg[k*8 +: 8];
			end
			if (reg_addr == 8'(WAKE_EN_BASE + k)) begin
				rdata_next = wake_en_reg[k*8 +: 8];
			end
		end
		for (int k = 0; k < NUM_INTR_REGS; k++) begin
			if (reg_addr == 8'(INTR_STS_BASE + k)) begin
				rdata_next = intr_sts_reg[k*8 +: 8];
			end
			if (reg_addr == 8'(INTR_EN_BASE + k)) begin
				rdata_next = intr_en_reg[k*8 +: 8];
			end
		end
		if (reg_addr == GLOBAL_WAKE_EN) begin
			rdata_next = {7'h00, global_wake_en_reg};
		end
		if (reg_addr == EE_STATUS_SUMMARY) begin
			rdata_next = {2'h0, ee_status_reg};
		end
		if (reg_addr == EE_DETECT_SELECT) begin
			rdata_next = {2'h0, ee_select_reg};
		end
		if (reg_addr == LED_ONE_CONTROL) begin
			rdata_next = led_ctl_reg[0];
		end
		if (reg_addr == LED_TWO_CONTROL) begin
			rdata_next = led_ctl_reg[1];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= ZERO_BYTE;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_next;
			end
		end
	end

	// registered pins and event outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= '0;
			pin_oe <= '0;
			wake_event_out <= 1'b0;
			intr_req_out <= 1'b0;
		end else begin
			pin_out <= out_next;
			pin_oe <= oe_next;
			wake_event_out <= global_wake_en_reg && |(wake_sts_reg & wake_en_reg);
			intr_req_out <= |(intr_sts_reg & intr_en_reg);
		end
	end

	// checks
	localparam int EE0_WAKE_BIT = 9;
	localparam int EE0_INTR_BIT = 1;
	localparam int EE0_SLOT = 9;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_clear_wake0;
		reg_wr && reg_addr == WAKE_STS_BASE && reg_wdata[0];
	endsequence
	sequence s_quiet_wake0;
		!wake_set[0];
	endsequence

	property p_w1c;
		(s_clear_wake0 and s_quiet_wake0) |=> !wake_sts_reg[0];
	endproperty
	a_w1c: assert property (p_w1c) else $error("wake status did not clear on one");

	property p_w0_keep;
		(wake_sts_reg[0] && !(reg_wr && reg_addr == WAKE_STS_BASE && reg_wdata[0])) |=> wake_sts_reg[0];
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("wake status lost without write");

	property p_wake_gate;
		wake_event_out == ($past(global_wake_en_reg) && $past(|(wake_sts_reg & wake_en_reg)));
	endproperty
	a_wake_gate: assert property (p_wake_gate) else $error("wake event gating wrong");

	property p_out_excl;
		(as_out[0] && !wake_sts_reg[0]) |=> !wake_sts_reg[0];
	endproperty
	a_out_excl: assert property (p_out_excl) else $error("output pin set wake status");

	property p_rise_sets;
		(!as_out[0] && !cfg_reg[0][CFG_POL_BIT] && pin_rise[0]) |=> wake_sts_reg[0];
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rising edge missed");

	property p_ee_both;
		(ee_select_reg[0] && pin_fall[EE0_SLOT]) |=> (wake_sts_reg[EE0_WAKE_BIT] && intr_sts_reg[EE0_INTR_BIT]);
	endproperty
	a_ee_both: assert property (p_ee_both) else $error("either-edge fall missed");

	property p_summary;
		(pin_rise[EE0_SLOT] || pin_fall[EE0_SLOT]) |=> ee_status_reg[0];
	endproperty
	a_summary: assert property (p_summary) else $error("summary bit missed edge");

	property p_intr_req;
		intr_req_out == $past(|(intr_sts_reg & intr_en_reg));
	endproperty
	a_intr_req: assert property (p_intr_req) else $error("interrupt request mismatch");

	property p_in_write;
		(reg_wr && reg_addr == DATA_BASE && !as_out[0]) |=> $stable(data_reg[0]);
	endproperty
	a_in_write: assert property (p_in_write) else $error("input data bit changed");

	property p_drive;
		(cfg_reg[0] == CFG_RESET_OUT && !ee_slot[0]) |=> (pin_oe[0] && pin_out[0] == $past(data_reg[0]));
	endproperty
	a_drive: assert property (p_drive) else $error("output pin not driving data");
endmodule
`default_nettype wire

// *** verilog/gwelp_pkg.sv ***
// Purpose: constants, register map and pin maps for the gpio wake/event/led port
// Assumes: 48 pin slots, slot = (group - 1) * 8 + bit, group 1..6
// Notes: slot 0 is port 10, slot 8 is port 20, slot 40 is port 60
package gwelp_pkg;
	localparam int NUM_SLOTS = 48;
	localparam int NUM_GROUPS = 6;
	localparam int NUM_WAKE_REGS = 4;
	localparam int NUM_INTR_REGS = 3;
	localparam int NUM_EE = 6;
	localparam int SYNC_EXTRA = 2;

	// register offsets
	localparam logic [7:0] CFG_BASE = 8'h00;
	localparam logic [7:0] WAKE_STS_BASE = 8'h30;
	localparam logic [7:0] WAKE_EN_BASE = 8'h34;
	localparam logic [7:0] INTR_STS_BASE = 8'h38;
	localparam logic [7:0] INTR_EN_BASE = 8'h3B;
	localparam logic [7:0] GLOBAL_WAKE_EN = 8'h3E;
	localparam logic [7:0] EE_STATUS_SUMMARY = 8'h3F;
	localparam logic [7:0] EE_DETECT_SELECT = 8'h40;
	localparam logic [7:0] DATA_BASE = 8'h4B;
	localparam logic [7:0] LED_ONE_CONTROL = 8'h5D;
	localparam logic [7:0] LED_TWO_CONTROL = 8'h5E;

	// configuration fields
	localparam int CFG_DIR_BIT = 0;
	localparam int CFG_POL_BIT = 1;
	localparam int CFG_FUNC_LSB = 2;
	localparam int CFG_FUNC_MSB = 3;
	localparam int CFG_TYPE_BIT = 7;
	localparam logic DIR_OUTPUT = 1'b0;
	localparam logic DIR_INPUT = 1'b1;
	localparam logic TYPE_OPEN_DRAIN = 1'b1;
	localparam logic [1:0] FUNC_PORT = 2'h0;
	localparam logic [7:0] CFG_RESET_IN = 8'h01;
	localparam logic [7:0] CFG_RESET_OUT = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// special slots
	localparam int SLOT_GROUP_INTR = 15;
	localparam int SLOT_DRIVE_DENSITY = 27;
	localparam int SLOT_LED_ONE = 40;
	localparam int SLOT_LED_TWO = 41;
	localparam logic [47:0] JOY_MASK = 48'h0000_0000_00F0;
	localparam logic [47:0] LED_MASK = 48'h0300_0000_0000;
	localparam logic [47:0] REVERT_MASK = 48'h0008_000C_0000;
	localparam logic [7:0] GROUP_MASK [0:5] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h03};

	// status bit to slot maps
	localparam logic [7:0] SLOT_NONE = 8'hFF;
	localparam logic [7:0] WAKE_MAP [0:31] = '{
		8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
		8'h08, 8'h09, 8'h0A, 8'hFF, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
		8'h10, 8'h11, 8'h12, 8'h13, 8'h19, 8'h1B, 8'h28, 8'h29,
		8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
	localparam logic [7:0] INTR_MAP [0:23] = '{
		8'h08, 8'h09, 8'h0A, 8'hFF, 8'h0C, 8'h0D, 8'h0E, 8'h28,
		8'h10, 8'h11, 8'h12, 8'h13, 8'h19, 8'h1A, 8'h1B, 8'h29,
		8'h24, 8'h25, 8'h26, 8'h27, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	localparam logic [7:0] EE_MAP [0:5] = '{8'h09, 8'h0A, 8'h19, 8'h1B, 8'h28, 8'h29};

	// led blinking, counted in standby clock edges
	localparam int STANDBY_CLK_HZ = 32768;
	localparam int BLINK_HALF_PERIOD_MS = 500;
	localparam int BLINK_HALF_EDGES = STANDBY_CLK_HZ * BLINK_HALF_PERIOD_MS / 1000;

	typedef enum logic [1:0] {
		GWELP_LED_OFF = 2'b00,
		GWELP_LED_BLINK = 2'b01,
		GWELP_LED_ON = 2'b10,
		GWELP_LED_ON_ALT = 2'b11
	} gwelp_led_mode_type;
endpackage

// *** verilog/gwelp_pin_sync.sv ***
// Purpose: two-stage pin synchroniser with edge detection
// Assumes: raw inputs are asynchronous to mclk
// Notes: edges are held off until both stages and the history carry real samples
`timescale 1ns/100ps
`default_nettype none
module gwelp_pin_sync #(
	parameter int WIDTH = 50
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// raw pins
	input wire logic [WIDTH-1:0] pin_raw,
	// synchronised level and edges
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;
	logic [2:0] primed_reg;

	if (WIDTH < 1) begin : g_check
		$error("gwelp_pin_sync needs at least one pin");
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= pin_raw;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			primed_reg <= 3'h0;
		end else begin
			primed_reg <= {primed_reg[1:0], 1'b1};
		end
	end

	assign level = sync_reg;
	assign rise = primed_reg[2] ? (sync_reg & ~prev_reg) : '0;
	assign fall = primed_reg[2] ? (~sync_reg & prev_reg) : '0;
endmodule
`default_nettype wire

// *** test/gwelp_board.sv ***
// Purpose: board model for the gpio port pins and the standby clock
// Assumes: every pin has a pull-up; external drivers act only when enabled
// Notes: standby clock stands still while sb_run is low
`timescale 1ns/100ps
`default_nettype none
module gwelp_board
	import gwelp_pkg::*;
(
	// device pins
	input wire logic [NUM_SLOTS-1:0] pin_out,
	input wire logic [NUM_SLOTS-1:0] pin_oe,
	output logic [NUM_SLOTS-1:0] pin_level,
	// external drivers
	input wire logic [NUM_SLOTS-1:0] ext_en,
	input wire logic [NUM_SLOTS-1:0] ext_val,
	// standby clock
	input wire logic sb_run,
	output logic standby_clk
);
	// device wins, then external driver, else pull-up
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
	initial standby_clk = 1'b0;
	always begin
		#15259;
		if (sb_run) begin
			standby_clk = ~standby_clk;
		end else begin
			standby_clk = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Purpose: self-checking bench for the gpio wake/event/led port
// Assumes: short blink count of 4 standby edges per half period
// Notes: inputs change on the falling edge of mclk
`timescale 1ns/100ps
`default_nettype none
module tb import gwelp_pkg::*;;
	logic mclk, rst_n, reg_wr, reg_rd, reg_rvalid, sb_run, standby_clk;
	logic main_power_off_pin, wake_event_out, intr_req_out;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [NUM_SLOTS-1:0] pin_in, pin_out, pin_oe, alt_out, ext_en, ext_val;
	int n_errors = 0;
	int n_compared = 0;

	gwelp_port #(.BLINK_EDGES(4)) dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.alt_out(alt_out), .standby_clk_pin(standby_clk),
		.main_power_off_pin(main_power_off_pin), .wake_event_out(wake_event_out),
		.intr_req_out(intr_req_out));
	gwelp_board board (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_in),
		.ext_en(ext_en), .ext_val(ext_val), .sb_run(sb_run), .standby_clk(standby_clk));

	always #5 mclk = ~mclk;

	task automatic test_done();
		if (n_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
		chk(nm, reg_rdata, exp);
	endtask
	task automatic settle();
		repeat (2) @(negedge mclk);
	endtask
	task automatic pin(input logic [7:0] s, input logic v);
		@(negedge mclk);
		ext_val[s] = v;
		repeat (5) @(negedge mclk);
	endtask
	task automatic t_reset();
		settle();
		chk("rev_oe", {5'h00, pin_oe[35], pin_oe[19], pin_oe[18]}, 8'h07);
		chk("rev_out", {5'h00, pin_out[35], pin_out[19], pin_out[18]}, 8'h00);
		rchk(CFG_BASE + 8'd18, CFG_RESET_OUT, "cfg18");
		rchk(CFG_BASE + 8'd27, CFG_RESET_IN, "cfg27");
		rchk(8'hF0, 8'h00, "unmapped");
	endtask
	task automatic t_output();
		wr(CFG_BASE, 8'h00);
		wr(DATA_BASE, 8'h01);
		settle();
		chk("out0", {6'h00, pin_oe[0], pin_out[0]}, 8'h03);
		wr(CFG_BASE, 8'h02);
		settle();
		chk("out0_inv", {6'h00, pin_oe[0], pin_out[0]}, 8'h02);
		rchk(DATA_BASE, 8'h01, "data_out");
		wr(CFG_BASE, 8'h80);
		settle();
		chk("od_high", {7'h00, pin_oe[0]}, 8'h00);
		pin(8'd0, 1'b1);
		rchk(WAKE_STS_BASE, 8'h00, "out_no_wake");
		pin(8'd0, 1'b0);
		wr(DATA_BASE, 8'h00);
		settle();
		chk("od_low", {6'h00, pin_oe[0], pin_out[0]}, 8'h02);
		wr(CFG_BASE, 8'h01);
		pin(8'd1, 1'b1);
		rchk(DATA_BASE, 8'h02, "data_in");
		wr(CFG_BASE + 8'd1, 8'h03);
		wr(DATA_BASE, 8'h02);
		rchk(DATA_BASE, 8'h00, "data_in_inv");
		pin(8'd1, 1'b0);
		wr(WAKE_STS_BASE, 8'hFF);
	endtask
	task automatic t_wake();
		pin(8'd0, 1'b1);
		rchk(WAKE_STS_BASE, 8'h01, "rise");
		wr(WAKE_STS_BASE, 8'h00);
		rchk(WAKE_STS_BASE, 8'h01, "clr0");
		wr(WAKE_EN_BASE, 8'h01);
		settle();
		chk("no_global", {7'h00, wake_event_out}, 8'h00);
		wr(GLOBAL_WAKE_EN, 8'h01);
		settle();
		chk("wake", {7'h00, wake_event_out}, 8'h01);
		wr(WAKE_STS_BASE, 8'h01);
		settle();
		chk("wake_clr", {7'h00, wake_event_out}, 8'h00);
		pin(8'd0, 1'b0);
		rchk(WAKE_STS_BASE, 8'h00, "fall");
		wr(CFG_BASE, 8'h03);
		settle();
		wr(WAKE_STS_BASE, 8'hFF);
		pin(8'd0, 1'b1);
		rchk(WAKE_STS_BASE, 8'h00, "inv_rise");
		pin(8'd0, 1'b0);
		rchk(WAKE_STS_BASE, 8'h01, "inv_fall");
		wr(WAKE_STS_BASE, 8'hFF);
		wr(GLOBAL_WAKE_EN, 8'h00);
	endtask
	task automatic t_map();
		logic [39:0] tbl [7] = '{40'h07_30_80_38_00, 40'h0F_31_80_38_00,
			40'h1B_32_20_39_40, 40'h27_33_80_3A_08, 40'h08_31_01_38_01,
			40'h1A_30_00_39_20, 40'h28_32_40_38_80};
		for (int a = 0; a < 4; a++) begin
			wr(WAKE_STS_BASE + a[7:0], 8'hFF);
			if (a < NUM_INTR_REGS) begin
				wr(INTR_STS_BASE + a[7:0], 8'hFF);
			end
		end
		for (int i = 0; i < 7; i++) begin
			pin(tbl[i][39:32], 1'b1);
			rchk(tbl[i][31:24], tbl[i][23:16], "wake_map");
			rchk(tbl[i][15:8], tbl[i][7:0], "intr_map");
			pin(tbl[i][39:32], 1'b0);
			wr(tbl[i][31:24], 8'hFF);
			wr(tbl[i][15:8], 8'hFF);
		end
		pin(8'd8, 1'b1);
		wr(INTR_EN_BASE, 8'h01);
		settle();
		chk("intr", {7'h00, intr_req_out}, 8'h01);
		wr(INTR_STS_BASE, 8'h01);
		settle();
		chk("intr_clr", {7'h00, intr_req_out}, 8'h00);
		wr(INTR_EN_BASE, 8'h00);
		pin(8'd8, 1'b0);
		wr(WAKE_STS_BASE + 8'd1, 8'hFF);
	endtask
	task automatic t_ee();
		wr(EE_STATUS_SUMMARY, 8'hFF);
		wr(EE_DETECT_SELECT, 8'h01);
		wr(CFG_BASE + 8'd9, 8'h02);
		settle();
		chk("ee_oe", {7'h00, pin_oe[9]}, 8'h00);
		for (int e = 1; e >= 0; e--) begin
			pin(8'd9, e[0]);
			rchk(WAKE_STS_BASE + 8'd1, 8'h02, "ee_wake");
			rchk(INTR_STS_BASE, 8'h02, "ee_intr");
			rchk(EE_STATUS_SUMMARY, 8'h01, "ee_sum");
			rchk(DATA_BASE + 8'd1, {6'h00, ~e[0], 1'b0}, "ee_data");
			if (e == 0) begin
				wr(WAKE_EN_BASE + 8'd1, 8'h02);
				wr(GLOBAL_WAKE_EN, 8'h01);
				settle();
				chk("ee_wake_ev", {7'h00, wake_event_out}, 8'h01);
				wr(CFG_BASE + 8'd9, 8'h03);
				wr(EE_DETECT_SELECT, 8'h00);
				wr(WAKE_STS_BASE + 8'd1, 8'hFF);
				pin(8'd9, 1'b1);
				chk("ee_unsel", {7'h00, wake_event_out}, 8'h00);
			end
			wr(WAKE_STS_BASE + 8'd1, 8'hFF);
			wr(INTR_STS_BASE, 8'hFF);
			wr(EE_STATUS_SUMMARY, 8'hFF);
			rchk(EE_STATUS_SUMMARY, 8'h00, "ee_clr");
		end
		wr(GLOBAL_WAKE_EN, 8'h00);
	endtask
	task automatic t_power();
		main_power_off_pin = 1'b1;
		wr(CFG_BASE + 8'd18, 8'h03);
		settle();
		chk("pwr_off", {6'h00, pin_oe[18], pin_out[18]}, 8'h02);
		main_power_off_pin = 1'b0;
		repeat (4) @(negedge mclk);
		chk("pwr_on", {7'h00, pin_oe[18]}, 8'h00);
	endtask
	task automatic t_alt();
		alt_out[27] = 1'b1;
		wr(CFG_BASE + 8'd5, 8'h06);
		wr(CFG_BASE + 8'd27, 8'h06);
		wr(CFG_BASE + 8'd15, 8'h84);
		settle();
		chk("joy", {6'h00, pin_oe[5], pin_out[5]}, 8'h02);
		chk("density", {6'h00, pin_oe[27], pin_out[27]}, 8'h03);
		chk("grp_intr", {6'h00, pin_oe[15], pin_out[15]}, 8'h00);
	endtask
	task automatic t_led();
		wr(CFG_BASE + 8'd40, 8'h04);
		wr(CFG_BASE + 8'd41, 8'h04);
		wr(LED_ONE_CONTROL, 8'h02);
		wr(LED_TWO_CONTROL, 8'h03);
		settle();
		chk("led_on", {6'h00, pin_out[41], pin_out[40]}, 8'h03);
		rchk(LED_ONE_CONTROL, 8'h02, "led_reg");
		wr(LED_ONE_CONTROL, 8'h00);
		settle();
		chk("led_off", {6'h00, pin_out[41], pin_out[40]}, 8'h02);
		wr(LED_ONE_CONTROL, 8'h01);
		repeat (4000) @(negedge mclk);
		chk("led_idle", {7'h00, pin_out[40]}, 8'h00);
		sb_run = 1'b1;
		repeat (3) @(posedge standby_clk);
		repeat (8) @(negedge mclk);
		chk("led_wait", {7'h00, pin_out[40]}, 8'h00);
		@(posedge standby_clk);
		repeat (8) @(negedge mclk);
		chk("led_blink", {7'h00, pin_out[40]}, 8'h01);
		sb_run = 1'b0;
	endtask

	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		alt_out = '0;
		main_power_off_pin = 1'b0;
		ext_en = '1;
		ext_val = '0;
		sb_run = 1'b0;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		t_reset();
		t_output();
		t_wake();
		t_map();
		t_ee();
		t_power();
		t_alt();
		t_led();
		test_done();
	end
	initial begin
		repeat (90000) @(posedge mclk);
		n_errors++;
		test_done();
	end
endmodule
`default_nettype wire
